// ### src/cpu_power_mode_control.sv
// Power mode controller for the processor core: idle, stop and shutdown wake.
// Assumes the core gives a write strobe, an instruction-done pulse, the OR
// of its enabled pending interrupts, and a synchronous external reset request.
//
// Summary of operation
// - Writing idle-select halts the CPU once the writing instruction finishes.
// - Idle gates only the CPU clock; peripherals and registers stay live.
// - Idle ends on any enabled interrupt or on a reset.
// - Interrupt wake clears idle-select and resumes the CPU to service it.
// - An external reset during idle runs the full reset sequence.
// - Writing stop-select halts the CPU and digital peripherals after the instruction.
// - Stop ends only through external reset, restarting program execution.
// - The system clock keeps running in stop.
// - Idle-select and stop-select always read back as zero.
// - Bits 7 to 2 are plain software flags with no hardware effect.
// - In shutdown a GPIO pulled to ground wakes the device.
`timescale 1ns/100ps
module cpu_power_mode_control
#(
   parameter int WAKE_PINS = 9
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_write,
   input wire logic [7:0] sfr_write_data,
   output logic [7:0] sfr_read_data,
   output logic sfr_read_hit,
   input wire logic instruction_done,
   input wire logic enabled_interrupt,
   input wire logic external_reset,
   input wire logic shutdown_active,
   input wire logic [WAKE_PINS-1:0] wake_gpio,
   output logic cpu_clock_enable,
   output logic peripheral_clock_enable,
   output logic system_clock_enable,
   output logic interrupt_wake,
   output logic full_reset_request,
   output logic shutdown_wake,
   output logic [1:0] power_mode
);
   // -----------------------------------------------------------------------
   // Register access
   // -----------------------------------------------------------------------
   wire logic reg_hit;
   wire logic write_hit;
   wire logic [7:0] read_value;
   wire logic idle_request;
   wire logic stop_request;
   wire logic [5:0] scratch_flags;

   // Decode of the single register address.
   assign reg_hit = (sfr_addr == power_mode_pkg::POWER_MODE_CONTROL_ADDR);
   assign write_hit = reg_hit & sfr_write;

   power_mode_register u_register
   (
      .clk(clk),
      .reset_n(reset_n),
      .write_hit(write_hit),
      .write_data(sfr_write_data),
      .read_value(read_value),
      .software_scratch_flags(scratch_flags),
      .idle_request(idle_request),
      .stop_request(stop_request)
   );

   // Read data is registered; the hit flag is a combinational handshake.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         sfr_read_data <= 8'h00;
      else
         sfr_read_data <= reg_hit ? read_value : 8'h00;
   end
   assign sfr_read_hit = reg_hit;

   // -----------------------------------------------------------------------
   // Mode state machine
   // -----------------------------------------------------------------------
   power_mode_pkg::power_mode_t mode;
   power_mode_pkg::power_mode_t next_mode;
   logic stop_armed;
   logic next_stop_armed;

   // The write and the completing instruction may coincide; both are held
   // pending until instruction_done so the CPU never halts mid-instruction.
   always_comb
   begin
      next_mode = mode;
      next_stop_armed = stop_armed;
      case (mode)
         power_mode_pkg::MODE_RUN:
         begin
            if (stop_request)
               next_stop_armed = 1'b1;
            if (stop_request | stop_armed)
            begin
               if (instruction_done)
               begin
                  next_mode = power_mode_pkg::MODE_STOP;
                  next_stop_armed = 1'b0;
               end
            end
            else if (idle_request)
               next_mode = instruction_done ? power_mode_pkg::MODE_IDLE
                                            : power_mode_pkg::MODE_IDLE_PENDING;
         end
         power_mode_pkg::MODE_IDLE_PENDING:
         begin
            if (instruction_done)
               next_mode = power_mode_pkg::MODE_IDLE;
         end
         power_mode_pkg::MODE_IDLE:
         begin
            if (enabled_interrupt)
               next_mode = power_mode_pkg::MODE_RUN;
         end
         power_mode_pkg::MODE_STOP:
         begin
            next_mode = power_mode_pkg::MODE_STOP;
         end
         default:
         begin
            next_mode = power_mode_pkg::MODE_RUN;
            next_stop_armed = 1'b0;
         end
      endcase
      // External reset overrides every mode and restarts the device.
      if (external_reset)
      begin
         next_mode = power_mode_pkg::MODE_RUN;
         next_stop_armed = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode <= power_mode_pkg::MODE_RUN;
         stop_armed <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         stop_armed <= next_stop_armed;
      end
   end

   // -----------------------------------------------------------------------
   // Clock gating and wake outputs
   // -----------------------------------------------------------------------
   // Idle gates only the CPU; stop also halts digital peripherals. The system
   // clock is never gated here, since stop leaves the oscillator running.
   assign cpu_clock_enable = (mode == power_mode_pkg::MODE_RUN)
                           | (mode == power_mode_pkg::MODE_IDLE_PENDING);
   assign peripheral_clock_enable = (mode != power_mode_pkg::MODE_STOP);
   assign system_clock_enable = 1'b1;
   assign power_mode = mode;

   // Interrupt resume is a one-cycle pulse; full reset request is external_reset delayed one cycle.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         interrupt_wake <= 1'b0;
         full_reset_request <= 1'b0;
      end
      else
      begin
         interrupt_wake <= (mode == power_mode_pkg::MODE_IDLE) & enabled_interrupt
                         & ~external_reset;
         full_reset_request <= external_reset;
      end
   end

   // -----------------------------------------------------------------------
   // Shutdown wake from grounded GPIO
   // -----------------------------------------------------------------------
   wire logic [WAKE_PINS-1:0] pin_low;

   genvar g;
   generate
      for (g = 0; g < WAKE_PINS; g++)
      begin : gen_wake
         wake_pin_filter u_filter
         (
            .clk(clk),
            .reset_n(reset_n),
            .pin(wake_gpio[g]),
            .pulled_low(pin_low[g])
         );
         // Two history stages, the filter output register and the wake register: four low samples are enough.
         AST_SHUTDOWN_WAKE: assert property (@(posedge clk) disable iff (!reset_n)
            (shutdown_active && !wake_gpio[g]) [*4] |=> shutdown_wake)
            else $error("Grounded GPIO did not wake.");
      end
   endgenerate

   // Wake is a level held while in shutdown and some pin is low.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         shutdown_wake <= 1'b0;
      else
         shutdown_wake <= shutdown_active & (|pin_low);
   end

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   AST_IDLE_AFTER_DONE: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_IDLE_PENDING && instruction_done && !external_reset)
      |=> (mode == power_mode_pkg::MODE_IDLE && !cpu_clock_enable))
      else $error("Idle not entered after instruction completed.");

   AST_IDLE_PERIPH_LIVE: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_IDLE) |-> (peripheral_clock_enable && !cpu_clock_enable))
      else $error("Idle gated the wrong clocks.");

   AST_IDLE_WAKE: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_IDLE && enabled_interrupt)
      |=> (mode == power_mode_pkg::MODE_RUN && cpu_clock_enable))
      else $error("Idle did not end on interrupt.");

   AST_WAKE_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_IDLE && enabled_interrupt && !external_reset)
      |=> interrupt_wake ##1 !interrupt_wake)
      else $error("Interrupt wake pulse wrong.");

   AST_RESET_SEQUENCE: assert property (@(posedge clk) disable iff (!reset_n)
      external_reset |=> (full_reset_request && mode == power_mode_pkg::MODE_RUN))
      else $error("External reset did not restart.");

   AST_STOP_ENTRY: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_RUN && (stop_request || stop_armed) && instruction_done
         && !external_reset)
      |=> (mode == power_mode_pkg::MODE_STOP && !peripheral_clock_enable))
      else $error("Stop not entered.");

   AST_STOP_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_STOP && !external_reset) |=> $stable(mode))
      else $error("Stop left without reset.");

   AST_SYSCLK_RUNS: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_STOP) |-> system_clock_enable)
      else $error("System clock stopped.");

   AST_MODE_BITS_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 sfr_read_data[1:0] == 2'h0)
      else $error("Mode bits read nonzero.");

   AST_SCRATCH_READBACK: assert property (@(posedge clk) disable iff (!reset_n)
      write_hit |=> (scratch_flags == $past(sfr_write_data[7:2])))
      else $error("Scratch flags not stored.");

   AST_READ_PATH: assert property (@(posedge clk) disable iff (!reset_n)
      reg_hit |=> (sfr_read_data[1:0] == 2'h0 && sfr_read_data[7:2] == $past(scratch_flags)))
      else $error("Register read data wrong.");

   AST_SCRATCH_NO_EFFECT: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_RUN && write_hit && !idle_request && !stop_request
         && !stop_armed && !external_reset)
      |=> (mode == power_mode_pkg::MODE_RUN))
      else $error("Scratch write changed the mode.");

   AST_PENDING_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_IDLE_PENDING && !instruction_done && !external_reset)
      |=> (mode == power_mode_pkg::MODE_IDLE_PENDING))
      else $error("Idle entered before the instruction completed.");

   AST_IDLE_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_IDLE && !enabled_interrupt && !external_reset)
      |=> (mode == power_mode_pkg::MODE_IDLE))
      else $error("Idle left without an interrupt or reset.");

   AST_WAKE_FROM_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
      interrupt_wake |-> ($past(mode) == power_mode_pkg::MODE_IDLE))
      else $error("Interrupt wake outside idle.");

   AST_RESET_QUIET: assert property (@(posedge clk) disable iff (!reset_n)
      !external_reset |=> !full_reset_request)
      else $error("Full reset requested without external reset.");

   AST_STOP_CPU_HALTED: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_STOP) |-> (!cpu_clock_enable && !peripheral_clock_enable))
      else $error("Stop left a clock running.");

   AST_STOP_NO_IRQ: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == power_mode_pkg::MODE_STOP) |=> !interrupt_wake)
      else $error("Interrupt acted in stop.");

   AST_PERIPH_OUTSIDE_STOP: assert property (@(posedge clk) disable iff (!reset_n)
      (mode != power_mode_pkg::MODE_STOP) |-> peripheral_clock_enable)
      else $error("Peripheral clock gated outside stop.");

   AST_WAKE_NEEDS_SHUTDOWN: assert property (@(posedge clk) disable iff (!reset_n)
      !shutdown_active |=> !shutdown_wake)
      else $error("Shutdown wake outside shutdown.");

   AST_RESET_CLEARS: assert property (@(posedge clk)
      !reset_n |=> (mode == power_mode_pkg::MODE_RUN
         && scratch_flags == power_mode_pkg::SCRATCH_RESET && !interrupt_wake))
      else $error("Reset left state behind.");
endmodule

// ### src/power_mode_pkg.sv
// Constants shared by the power mode controller and its helper modules.
// Assumes a core-side special-function register port with 8-bit addresses.
package power_mode_pkg;
   // -----------------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------------
   localparam logic [7:0] POWER_MODE_CONTROL_ADDR = 8'h87;
   localparam logic [7:0] POWER_MODE_CONTROL_RESET = 8'h00;
   localparam int IDLE_SELECT_POS = 0;
   localparam int STOP_SELECT_POS = 1;
   localparam int SCRATCH_LSB = 2;
   localparam int SCRATCH_MSB = 7;
   localparam int SCRATCH_WIDTH = 6;
   localparam logic [5:0] SCRATCH_RESET = 6'h00;

   // -----------------------------------------------------------------------
   // Mode encoding
   // -----------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      MODE_RUN = 2'b00,
      MODE_IDLE_PENDING = 2'b01,
      MODE_IDLE = 2'b10,
      MODE_STOP = 2'b11
   } power_mode_t;

   // Number of samples a GPIO wake input must stay low before it counts.
   localparam int WAKE_FILTER_DEPTH = 2;
endpackage

// ### src/wake_pin_filter.sv
// Low-level filter for one GPIO wake input.
// Assumes the pin is synchronous to clk, as the core samples its ports.
`timescale 1ns/100ps
module wake_pin_filter
#(
   parameter int DEPTH = power_mode_pkg::WAKE_FILTER_DEPTH
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic pin,
   output logic pulled_low
);
   logic [DEPTH-1:0] history;

   // -----------------------------------------------------------------------
   // Shift in the inverted pin level.
   // -----------------------------------------------------------------------
   // A few samples suppress a single-cycle glitch on a long board trace.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         history <= '0;
      else
         history <= {history[DEPTH-2:0], ~pin};
   end

   // Registered so the output is a clean level.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pulled_low <= 1'b0;
      else
         pulled_low <= &history;
   end
endmodule

// ### src/power_mode_register.sv
// Power mode control register with its write-to-trigger mode bits.
// Assumes one write strobe from the core per completed register write.
`timescale 1ns/100ps
module power_mode_register
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic write_hit,
   input wire logic [7:0] write_data,
   output logic [7:0] read_value,
   output logic [5:0] software_scratch_flags,
   output logic idle_request,
   output logic stop_request
);
   // -----------------------------------------------------------------------
   // Scratch flag storage.
   // -----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         software_scratch_flags <= power_mode_pkg::SCRATCH_RESET;
      else if (write_hit)
         software_scratch_flags <=
            write_data[power_mode_pkg::SCRATCH_MSB:power_mode_pkg::SCRATCH_LSB];
   end

   // Mode bits are not stored; they only pulse a request on the write.
   assign idle_request = write_hit & write_data[power_mode_pkg::IDLE_SELECT_POS];
   assign stop_request = write_hit & write_data[power_mode_pkg::STOP_SELECT_POS];

   // Mode bits always read as zero.
   assign read_value = {software_scratch_flags, 2'h0};
endmodule

// ### test/cpu_core_model.sv
// Behavioural processor core facing the power mode controller.
// Assumes one system clock; every line changes only at a falling edge.
`timescale 1ns/100ps
module cpu_core_model
(
   input wire logic clk,
   output logic [7:0] sfr_addr,
   output logic sfr_write,
   output logic [7:0] sfr_write_data,
   input wire logic [7:0] sfr_read_data,
   output logic instruction_done,
   output logic enabled_interrupt,
   output logic external_reset
);
   // ----------------------------------------------------------------------
   // Quiet core lines
   // ----------------------------------------------------------------------
   // All lines start quiet so nothing is requested while reset is held.
   initial
   begin
      sfr_addr = 8'h00;
      sfr_write = 1'b0;
      sfr_write_data = 8'h00;
      instruction_done = 1'b0;
      enabled_interrupt = 1'b0;
      external_reset = 1'b0;
   end

   // ----------------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------------
   // One register write; done says whether the instruction ends with it.
   // Data is inverted once taken, so the block cannot lean on stale data.
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic done);
      @(negedge clk);
      sfr_addr = a;
      sfr_write = 1'b1;
      sfr_write_data = d;
      instruction_done = done;
      @(negedge clk);
      sfr_write = 1'b0;
      sfr_write_data = ~d;
      // The address stays on the register, as the multi-byte copy does.
      instruction_done = 1'b0;
   endtask

   // Read data is registered, so two edges pass before it is taken.
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      repeat (2) @(negedge clk);
      d = sfr_read_data;
   endtask

   // Completes the instruction still in flight.
   task automatic finish_instruction();
      @(negedge clk);
      instruction_done = 1'b1;
      @(negedge clk);
      instruction_done = 1'b0;
   endtask

   // Sets the interrupt and reset request levels.
   task automatic set_lines(input logic irq, input logic rst);
      @(negedge clk);
      enabled_interrupt = irq;
      external_reset = rst;
   endtask
endmodule

// ### test/cpu_power_mode_control_tb.sv
// Self-checking bench for the power mode controller.
// Assumes the core model drives the register port and core lines.
`timescale 1ns/100ps
module cpu_power_mode_control_tb;
   logic clk;
   logic reset_n;
   logic shutdown_active;
   logic [8:0] wake_gpio;
   wire [7:0] sfr_addr;
   wire sfr_write;
   wire [7:0] sfr_write_data;
   wire instruction_done;
   wire enabled_interrupt;
   wire external_reset;
   logic [7:0] sfr_read_data;
   logic sfr_read_hit;
   logic cpu_clock_enable;
   logic peripheral_clock_enable;
   logic system_clock_enable;
   logic interrupt_wake;
   logic full_reset_request;
   logic shutdown_wake;
   logic [1:0] power_mode;
   int miscompares = 0;
   int checks_done = 0;

   cpu_power_mode_control DUT (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
      .sfr_write(sfr_write), .sfr_write_data(sfr_write_data), .sfr_read_data(sfr_read_data),
      .sfr_read_hit(sfr_read_hit), .instruction_done(instruction_done),
      .enabled_interrupt(enabled_interrupt), .external_reset(external_reset),
      .shutdown_active(shutdown_active), .wake_gpio(wake_gpio),
      .cpu_clock_enable(cpu_clock_enable), .peripheral_clock_enable(peripheral_clock_enable),
      .system_clock_enable(system_clock_enable), .interrupt_wake(interrupt_wake),
      .full_reset_request(full_reset_request), .shutdown_wake(shutdown_wake),
      .power_mode(power_mode));

   cpu_core_model core (.clk(clk), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
      .sfr_write_data(sfr_write_data), .sfr_read_data(sfr_read_data),
      .instruction_done(instruction_done), .enabled_interrupt(enabled_interrupt),
      .external_reset(external_reset));

   // ----------------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------------
   // Compares one value and counts it.
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask

   // Mode and clocks together; the system clock must always run.
   task automatic state(input logic [1:0] m, input logic c, input logic p);
      check("mode_and_clocks", {3'h0, m, c, p, 1'b1}, {3'h0, power_mode, cpu_clock_enable,
         peripheral_clock_enable, system_clock_enable});
   endtask

   // Interrupt wake, full reset and shutdown wake outputs.
   task automatic pulses(input logic [2:0] e);
      check("wake_and_reset", {5'h00, e}, {5'h00, interrupt_wake, full_reset_request,
         shutdown_wake});
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Reset state, scratch flags, read-as-zero bits and an unmapped read.
   task automatic registers();
      logic [7:0] d;
      state(power_mode_pkg::MODE_RUN, 1'b1, 1'b1);
      pulses(3'h0);
      core.read_reg(8'h87, d);
      check("power_mode_control", 8'h00, d);
      check("read_hit", 8'h01, {7'h00, sfr_read_hit});
      core.write_reg(8'h87, 8'hfc, 1'b1);
      core.write_reg(8'h87, 8'h54, 1'b1);
      core.read_reg(8'h87, d);
      check("power_mode_control", 8'h54, d);
      state(power_mode_pkg::MODE_RUN, 1'b1, 1'b1);
      core.read_reg(8'h86, d);
      check("unmapped", 8'h00, d);
      check("read_hit", 8'h00, {7'h00, sfr_read_hit});
   endtask

   // Idle waits for the instruction, keeps flags and ends on an interrupt.
   task automatic idle_wake();
      logic [7:0] d;
      core.write_reg(8'h87, 8'ha5, 1'b0);
      state(power_mode_pkg::MODE_IDLE_PENDING, 1'b1, 1'b1);
      core.finish_instruction();
      state(power_mode_pkg::MODE_IDLE, 1'b0, 1'b1);
      core.read_reg(8'h87, d);
      check("power_mode_control", 8'ha4, d);
      state(power_mode_pkg::MODE_IDLE, 1'b0, 1'b1);
      core.set_lines(1'b1, 1'b0);
      @(negedge clk);
      state(power_mode_pkg::MODE_RUN, 1'b1, 1'b1);
      pulses(3'h4);
      core.set_lines(1'b0, 1'b0);
      pulses(3'h0);
   endtask

   // Idle ended by an external reset runs the full reset.
   task automatic idle_reset();
      core.write_reg(8'h87, 8'h01, 1'b1);
      state(power_mode_pkg::MODE_IDLE, 1'b0, 1'b1);
      core.set_lines(1'b0, 1'b1);
      @(negedge clk);
      state(power_mode_pkg::MODE_RUN, 1'b1, 1'b1);
      pulses(3'h2);
      core.set_lines(1'b0, 1'b0);
   endtask

   // Stop beats idle, ignores interrupts and idle writes, ends on reset.
   task automatic stop_mode();
      logic [7:0] d;
      core.write_reg(8'h87, 8'h03, 1'b0);
      state(power_mode_pkg::MODE_RUN, 1'b1, 1'b1);
      core.finish_instruction();
      state(power_mode_pkg::MODE_STOP, 1'b0, 1'b0);
      core.set_lines(1'b1, 1'b0);
      core.write_reg(8'h87, 8'h01, 1'b1);
      core.read_reg(8'h87, d);
      check("power_mode_control", 8'h00, d);
      state(power_mode_pkg::MODE_STOP, 1'b0, 1'b0);
      pulses(3'h0);
      core.set_lines(1'b0, 1'b1);
      @(negedge clk);
      state(power_mode_pkg::MODE_RUN, 1'b1, 1'b1);
      pulses(3'h2);
      core.set_lines(1'b0, 1'b0);
   endtask

   // One grounded pin in shutdown wakes the device; high pins do not.
   task automatic shutdown();
      int n;
      shutdown_active = 1'b1;
      repeat (6) @(negedge clk);
      pulses(3'h0);
      wake_gpio[4] = 1'b0;
      for (n = 0; n < 8 && shutdown_wake !== 1'b1; n++) @(negedge clk);
      pulses(3'h1);
      repeat (2) @(negedge clk);
      pulses(3'h1);
      shutdown_active = 1'b0;
      wake_gpio[4] = 1'b1;
      @(negedge clk);
      pulses(3'h0);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Clock, sequence and watchdog
   // ----------------------------------------------------------------------
   // A 4 ns clock stands for the 250 MHz system clock.
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Reset is held 16 cycles, then the scenarios run in turn.
   initial
   begin
      reset_n = 1'b0;
      shutdown_active = 1'b0;
      wake_gpio = 9'h1ff;
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      registers();
      idle_wake();
      idle_reset();
      stop_mode();
      shutdown();
      wrap_up();
   end

   // Reset and the scenarios take some 70 cycles; this cuts a hang far beyond.
   initial
   begin
      #20000;
      miscompares++;
      wrap_up();
   end
endmodule
